//--- design/igr_defs.svh
// register offsets, field positions and reset values of the group router
// assumes byte addressing on a 32-bit wishbone slave, word aligned
`ifndef IGR_DEFS_SVH
`define IGR_DEFS_SVH

`define IGR_NUM_IRQ        8
`define IGR_ADR_W          14

// distributor side
`define IGR_DIST_CTRL      14'h0000
`define IGR_GROUP_BITS     14'h0080
`define IGR_SET_PEND       14'h0200
`define IGR_PRIO_LO        14'h0400
`define IGR_PRIO_HI        14'h0404

// cpu interface side
`define IGR_CPU_CTRL       14'h1000
`define IGR_PRIO_MASK      14'h1004
`define IGR_BP_PRIMARY     14'h1008
`define IGR_ACK_PRIMARY    14'h100c
`define IGR_EOI_PRIMARY    14'h1010
`define IGR_RUN_PRIO       14'h1014
`define IGR_HIGH_PEND      14'h1018
`define IGR_BP_ALIASED     14'h101c
`define IGR_ACK_ALIASED    14'h1020
`define IGR_EOI_ALIASED    14'h1024

// event status, enable and clear
`define IGR_EVT_STATUS     14'h2000
`define IGR_EVT_ENABLE     14'h2004
`define IGR_EVT_CLEAR      14'h2008

// control fields
`define IGR_F_G0EN         0
`define IGR_F_G1EN         1
`define IGR_F_ACK_CONTROL  2
`define IGR_F_FIQSEL       3
`define IGR_F_CBP          4

// event bits
`define IGR_E_SPURIOUS     0
`define IGR_E_RO_WRITE     1
`define IGR_E_EOI_BAD      2

// reset values; group bits all group 0 on reset
`define IGR_GROUP_RST      8'h00
`define IGR_BP_RST         3'h2
`define IGR_ID_SPURIOUS    10'h3ff
`define IGR_ID_OTHER_GRP   10'h3fe
`define IGR_PRIO_IDLE      8'hff

`endif

//--- design/igr_pkg.sv
// types of the interrupt group router
// assumes igr_defs.svh on the include path
`include "igr_defs.svh"

package igr_pkg;

	typedef struct packed {
		logic [1:0]                 dctl;
		logic [`IGR_NUM_IRQ-1:0]    group;
		logic [4:0]                 cctl;
		logic [7:0]                 pmr;
		logic [2:0]                 bpr;
		logic [2:0]                 abpr;
		logic [`IGR_NUM_IRQ-1:0]    pend;
		logic [`IGR_NUM_IRQ-1:0]    act;
		logic [8*`IGR_NUM_IRQ-1:0]  prio;
		logic [2:0]                 evt_stat;
		logic [2:0]                 evt_en;
		logic [`IGR_NUM_IRQ-1:0]    src_prev;
		logic                       ack;
		logic [31:0]                rdat;
		logic                       fiq;
		logic                       irq;
		logic                       intr;
	} igr_state_t;

	typedef struct packed {
		logic [`IGR_NUM_IRQ-1:0] s1;
		logic [`IGR_NUM_IRQ-1:0] s2;
		logic [`IGR_NUM_IRQ-1:0] s3;
		logic [`IGR_NUM_IRQ-1:0] lvl;
	} igr_sync_t;

endpackage : igr_pkg

//--- design/igr_sync.sv
// three-stage synchroniser for the interrupt source pins
// assumes sources are asynchronous levels; output is a filtered level
`timescale 1ns/1ps
`include "igr_defs.svh"

module igr_sync
	import igr_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// pins in, level out
	input  wire logic [`IGR_NUM_IRQ-1:0] pin_i,
	output logic      [`IGR_NUM_IRQ-1:0] lvl_o
);

	igr_sync_t q;
	igr_sync_t d;

	always_comb begin
		d    = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// only take a change once stages two and three agree
		for (int i = 0; i < `IGR_NUM_IRQ; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.lvl[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lvl_o = q.lvl;

endmodule : igr_sync

//--- design/igr_pick.sv
// highest priority pending interrupt, masked by distributor group enables
// assumes lower priority value is more urgent; ties go to the lower id
`timescale 1ns/1ps
`include "igr_defs.svh"

module igr_pick
	import igr_pkg::*;
(
	// candidate state
	input  wire logic [`IGR_NUM_IRQ-1:0]   cand_i,
	input  wire logic [`IGR_NUM_IRQ-1:0]   group_i,
	input  wire logic [1:0]                dctl_i,
	input  wire logic [8*`IGR_NUM_IRQ-1:0] prio_i,
	// winner
	output logic                           valid_o,
	output logic [2:0]                     id_o,
	output logic                           grp0_o,
	output logic [7:0]                     prio_o
);

	always_comb begin
		valid_o = 1'b0;
		id_o    = 3'h0;
		prio_o  = `IGR_PRIO_IDLE;
		for (int i = 0; i < `IGR_NUM_IRQ; i++) begin
			// each distributor enable gates only its own group
			if (cand_i[i] && (group_i[i] ? dctl_i[`IGR_F_G1EN] : dctl_i[`IGR_F_G0EN])) begin // RULE4
				if (!valid_o || prio_i[8*i +: 8] < prio_o) begin
					valid_o = 1'b1;
					id_o    = 3'(i);
					prio_o  = prio_i[8*i +: 8];
				end
			end
		end
		grp0_o = !group_i[id_o]; // RULE2
	end

endmodule : igr_pick

//--- design/igr_router.sv
// interrupt group router: distributor, one cpu interface, wishbone slave
// assumes classic wishbone master on clk_i; sources are async level pins
//
// What this block does
// RULE1: after reset every interrupt sits in group 0, the secure group.
// RULE2: a writable group bit per interrupt marks group 1, the non-secure group.
// RULE3: with fast-request select set, group 0 goes out on fast request, group 1 on normal.
// RULE4: distributor enables for group 0 and group 1 each gate only their own group.
// RULE5: cpu interface enables for each group are separate from each other and the distributor.
// RULE6: with acknowledge control 0, primary ack takes group 0 and aliased ack takes group 1.
// RULE7: with acknowledge control 0, primary eoi ends group 0 and aliased eoi ends group 1.
// RULE8: aliased ack and eoi exist here; software may still use acknowledge control 1.
// RULE9: with common binary point 0, group 0 uses primary and group 1 aliased binary point.
// RULE10: with common binary point 1, both groups use the primary binary point.
// RULE11: read-only registers return their value and store nothing on a write; each write sets the read-only write event bit.
// RULE12: write-only registers act on writes and read back an unspecified value (zero).
// RULE13: group bit reset value is an implementation choice, here group 0.
// RULE14: the processor routes fast requests to its secure monitor and keeps normal masked.
// RULE15: group 0 with fast select drives fast request only if interface group 0 is enabled.
// RULE16: all bits sit in 32-bit registers; request outputs follow one cycle after a write.
`timescale 1ns/1ps
`include "igr_defs.svh"

module igr_router
	import igr_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// wishbone slave
	input  wire logic [`IGR_ADR_W-1:0]   adr_i,
	input  wire logic [31:0]             dat_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic                    we_i,
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	output logic      [31:0]             dat_o,
	output logic                         ack_o,
	// interrupt source pins
	input  wire logic [`IGR_NUM_IRQ-1:0] src_i,
	// requests to the processor
	output logic                         fiq_o,
	output logic                         irq_o,
	// event interrupt
	output logic                         int_o
);

	igr_state_t q;
	igr_state_t d;

	logic [`IGR_NUM_IRQ-1:0] src_lvl;
	logic                    hp_valid;
	logic [2:0]              hp_id;
	logic                    hp_grp0;
	logic [7:0]              hp_prio;

	igr_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i (src_i),
		.lvl_o (src_lvl)
	);

	// active interrupts cannot be picked again until completed
	igr_pick u_pick (
		.cand_i  (q.pend & ~q.act),
		.group_i (q.group),
		.dctl_i  (q.dctl),
		.prio_i  (q.prio),
		.valid_o (hp_valid),
		.id_o    (hp_id),
		.grp0_o  (hp_grp0),
		.prio_o  (hp_prio)
	);

	// byte lane merge of a write
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	// priority bits that take part in preemption for a binary point
	function automatic logic [7:0] bp_mask(input logic [2:0] bp);
		logic [7:0] m;
		m = 8'hff << bp;
		m = m << 1;
		return m;
	endfunction : bp_mask

	// running priority: most urgent active interrupt, idle when none
	function automatic logic [7:0] run_prio(input logic [`IGR_NUM_IRQ-1:0] act,
		input logic [8*`IGR_NUM_IRQ-1:0] prio);
		logic [7:0] r;
		r = `IGR_PRIO_IDLE;
		for (int i = 0; i < `IGR_NUM_IRQ; i++) begin
			if (act[i] && prio[8*i +: 8] < r) begin
				r = prio[8*i +: 8];
			end
		end
		return r;
	endfunction : run_prio

	logic [7:0]              rpr;
	logic [7:0]              pre_mask;
	logic                    next_int;
	logic                    req;
	logic [`IGR_ADR_W-1:0]   wadr;
	logic [31:0]             wval;
	logic [`IGR_NUM_IRQ-1:0] pend_set;
	logic [`IGR_NUM_IRQ-1:0] pend_clr;
	logic [`IGR_NUM_IRQ-1:0] act_set;
	logic [`IGR_NUM_IRQ-1:0] act_clr;
	logic [2:0]              evt_set;
	logic [2:0]              evt_clr;
	logic [9:0]              eoi_id;
	logic [2:0]              eoi_idx;

	always_comb begin
		rpr = run_prio(q.act, q.prio);
		// group 1 takes the primary point when the point is shared
		if (hp_grp0 || q.cctl[`IGR_F_CBP]) begin // RULE10
			pre_mask = bp_mask(q.bpr);
		end else begin
			pre_mask = bp_mask(q.abpr); // RULE9
		end
		next_int = hp_valid && (hp_prio < q.pmr) &&
			((q.act == '0) || (hp_prio < (rpr & pre_mask)));
	end

	always_comb begin
		d        = q;
		req      = cyc_i && stb_i && !q.ack;
		wadr     = {adr_i[`IGR_ADR_W-1:2], 2'b00};
		wval     = 32'h0;
		pend_set = src_lvl & ~q.src_prev;
		pend_clr = '0;
		act_set  = '0;
		act_clr  = '0;
		evt_set  = 3'h0;
		evt_clr  = 3'h0;
		eoi_id   = dat_i[9:0];
		eoi_idx  = dat_i[2:0];
		d.src_prev = src_lvl;
		// one-cycle ack; the master must drop stb before the next request
		d.ack    = req;
		if (req && we_i) begin
			case (wadr)
				`IGR_DIST_CTRL: begin
					wval   = lane_merge({30'h0, q.dctl}, dat_i, sel_i);
					d.dctl = wval[1:0]; // RULE16
				end
				`IGR_GROUP_BITS: begin
					wval    = lane_merge({24'h0, q.group}, dat_i, sel_i);
					d.group = wval[`IGR_NUM_IRQ-1:0]; // RULE2
				end
				`IGR_SET_PEND: begin
					if (sel_i[0]) begin
						pend_set = pend_set | dat_i[`IGR_NUM_IRQ-1:0];
					end
				end
				`IGR_PRIO_LO: begin
					d.prio[31:0] = lane_merge(q.prio[31:0], dat_i, sel_i);
				end
				`IGR_PRIO_HI: begin
					d.prio[63:32] = lane_merge(q.prio[63:32], dat_i, sel_i);
				end
				`IGR_CPU_CTRL: begin
					wval   = lane_merge({27'h0, q.cctl}, dat_i, sel_i);
					d.cctl = wval[4:0]; // RULE5
				end
				`IGR_PRIO_MASK: begin
					wval  = lane_merge({24'h0, q.pmr}, dat_i, sel_i);
					d.pmr = wval[7:0];
				end
				`IGR_BP_PRIMARY: begin
					if (sel_i[0]) begin
						d.bpr = dat_i[2:0];
					end
				end
				`IGR_BP_ALIASED: begin
					if (sel_i[0]) begin
						d.abpr = dat_i[2:0];
					end
				end
				`IGR_EOI_PRIMARY, `IGR_EOI_ALIASED: begin
					// primary ends group 0, or either group under ack control; aliased ends group 1
					if (eoi_id < 10'(`IGR_NUM_IRQ) && q.act[eoi_idx] &&
						((wadr == `IGR_EOI_PRIMARY && (!q.group[eoi_idx] ||
						q.cctl[`IGR_F_ACK_CONTROL])) ||
						(wadr == `IGR_EOI_ALIASED && q.group[eoi_idx]))) begin // RULE7
						act_clr[eoi_idx] = 1'b1; // RULE12
					end else begin
						evt_set[`IGR_E_EOI_BAD] = 1'b1;
					end
				end
				`IGR_EVT_ENABLE: begin
					if (sel_i[0]) begin
						d.evt_en = dat_i[2:0];
					end
				end
				`IGR_EVT_CLEAR: begin
					if (sel_i[0]) begin
						evt_clr = dat_i[2:0];
					end
				end
				`IGR_ACK_PRIMARY, `IGR_ACK_ALIASED, `IGR_RUN_PRIO,
				`IGR_HIGH_PEND, `IGR_EVT_STATUS: begin
					// read-only: nothing stored, only flagged
					evt_set[`IGR_E_RO_WRITE] = 1'b1; // RULE11
				end
				default: begin
				end
			endcase
		end
		if (req && !we_i) begin
			case (wadr)
				`IGR_DIST_CTRL:   d.rdat = {30'h0, q.dctl};
				`IGR_GROUP_BITS:  d.rdat = {24'h0, q.group};
				`IGR_SET_PEND:    d.rdat = {24'h0, q.pend};
				`IGR_PRIO_LO:     d.rdat = q.prio[31:0];
				`IGR_PRIO_HI:     d.rdat = q.prio[63:32];
				`IGR_CPU_CTRL:    d.rdat = {27'h0, q.cctl};
				`IGR_PRIO_MASK:   d.rdat = {24'h0, q.pmr};
				`IGR_BP_PRIMARY:  d.rdat = {29'h0, q.bpr};
				`IGR_BP_ALIASED:  d.rdat = {29'h0, q.abpr};
				`IGR_RUN_PRIO:    d.rdat = {24'h0, rpr};
				`IGR_HIGH_PEND: begin
					d.rdat = hp_valid ? {29'h0, hp_id} : {22'h0, `IGR_ID_SPURIOUS};
				end
				`IGR_EVT_STATUS:  d.rdat = {29'h0, q.evt_stat};
				`IGR_EVT_ENABLE:  d.rdat = {29'h0, q.evt_en};
				`IGR_ACK_PRIMARY: begin
					// primary takes group 0, or either group under ack control
					if (next_int && (hp_grp0 || q.cctl[`IGR_F_ACK_CONTROL])) begin // RULE6
						d.rdat           = {29'h0, hp_id};
						pend_clr[hp_id]  = 1'b1;
						act_set[hp_id]   = 1'b1;
					end else begin
						d.rdat = next_int ? {22'h0, `IGR_ID_OTHER_GRP} :
							{22'h0, `IGR_ID_SPURIOUS};
						evt_set[`IGR_E_SPURIOUS] = 1'b1;
					end
				end
				`IGR_ACK_ALIASED: begin
					if (next_int && !hp_grp0) begin // RULE8
						d.rdat           = {29'h0, hp_id};
						pend_clr[hp_id]  = 1'b1;
						act_set[hp_id]   = 1'b1;
					end else begin
						d.rdat = {22'h0, `IGR_ID_SPURIOUS};
						evt_set[`IGR_E_SPURIOUS] = 1'b1;
					end
				end
				default: d.rdat = 32'h0; // RULE12
			endcase
		end
		// a new edge wins over an acknowledge in the same cycle
		d.pend     = (q.pend & ~pend_clr) | pend_set;
		d.act      = (q.act & ~act_clr) | act_set;
		d.evt_stat = (q.evt_stat & ~evt_clr) | evt_set;
		d.intr     = |(d.evt_stat & d.evt_en);
		// request outputs, registered once after the state they follow
		d.fiq = 1'b0;
		d.irq = 1'b0;
		if (next_int) begin
			if (hp_grp0 && q.cctl[`IGR_F_FIQSEL]) begin // RULE3
				d.fiq = q.cctl[`IGR_F_G0EN]; // RULE15
			end else begin
				d.irq = hp_grp0 ? q.cctl[`IGR_F_G0EN] : q.cctl[`IGR_F_G1EN]; // RULE5
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q       <= '0;
			q.group <= `IGR_GROUP_RST; // RULE1 RULE13
			q.bpr   <= `IGR_BP_RST;
			q.abpr  <= `IGR_BP_RST;
		end else begin
			q <= d;
		end
	end

	assign dat_o = q.rdat;
	assign ack_o = q.ack;
	assign fiq_o = q.fiq;
	assign irq_o = q.irq;
	assign int_o = q.intr;

endmodule : igr_router

//--- verification/igr_router_asserts.sv
// port assertions and covers for the group router
// assumes one clock, classic wishbone master with a gap after each ack
`timescale 1ns/1ps
`include "igr_defs.svh"
module igr_router_asserts (
	// clock and reset
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	// wishbone
	input wire logic [`IGR_ADR_W-1:0]   adr_i,
	input wire logic [31:0]             dat_i,
	input wire logic [3:0]              sel_i,
	input wire logic                    we_i,
	input wire logic                    cyc_i,
	input wire logic                    stb_i,
	input wire logic [31:0]             dat_o,
	input wire logic                    ack_o,
	// pins and requests
	input wire logic [`IGR_NUM_IRQ-1:0] src_i,
	input wire logic                    fiq_o,
	input wire logic                    irq_o,
	input wire logic                    int_o
);
	logic rq;
	logic wq;
	assign rq = cyc_i && stb_i && !ack_o;
	assign wq = rq && we_i && sel_i[0];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	ack_one_cycle_a: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	ack_follows_a: assert property (rq |=> ack_o)
		else $error("ack missing after request");
	ack_cause_a: assert property (ack_o |-> $past(rq))
		else $error("ack without request");
	one_request_a: assert property (!(fiq_o && irq_o))
		else $error("fast and normal request together");
	reset_quiet_a: assert property ($past(rst_i) |-> !fiq_o && !irq_o && !int_o)
		else $error("request right after reset");
	cpu_off_a: assert property (wq && adr_i == `IGR_CPU_CTRL && dat_i[1:0] == 2'h0
		|-> ##2 !fiq_o && !irq_o) else $error("request with cpu enables off");
	dist_off_a: assert property (wq && adr_i == `IGR_DIST_CTRL && dat_i[1:0] == 2'h0
		|-> ##2 !fiq_o && !irq_o) else $error("request with distributor off");
	evt_off_a: assert property (wq && adr_i == `IGR_EVT_ENABLE && dat_i[2:0] == 3'h0
		|-> ##2 !int_o) else $error("event interrupt while disabled");
	wo_read_a: assert property (rq && !we_i && adr_i == `IGR_EOI_PRIMARY
		|=> ack_o && dat_o == 32'h0) else $error("write-only read not zero");
	read_hold_a: assert property (!(rq && !we_i) |=> $stable(dat_o))
		else $error("read data moved without read");
	cover property (fiq_o);
	cover property (irq_o);
	cover property (int_o);
endmodule : igr_router_asserts

bind igr_router igr_router_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
	.dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.dat_o(dat_o), .ack_o(ack_o), .src_i(src_i), .fiq_o(fiq_o), .irq_o(irq_o),
	.int_o(int_o));

//--- verification/igr_core_model.sv
// processor core taking fast and normal requests
// assumes active high level requests from the router
`timescale 1ns/1ps
module igr_core_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// requests
	input  wire logic       fiq_i,
	input  wire logic       irq_i,
	// state seen by the bench
	output logic            secure_o,
	output logic [7:0]      irq_cnt_o
);
	logic irq_prev_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			secure_o   <= 1'b0;
			irq_cnt_o  <= 8'h00;
			irq_prev_q <= 1'b0;
		end else begin
			secure_o   <= fiq_i;
			irq_prev_q <= irq_i;
			// normal requests stay masked while secure
			if (irq_i && !irq_prev_q && !secure_o)
				irq_cnt_o <= irq_cnt_o + 8'h01;
		end
	end
endmodule : igr_core_model

//--- verification/test_interrupt_group_signal_routing.sv
// self-checking bench for the group router over wishbone
// assumes the checker is bound into the router
`timescale 1ns/1ps
`include "igr_defs.svh"
module test_interrupt_group_signal_routing;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [13:0] adr_i = 14'h0;
	logic [31:0] dat_i = 32'h0;
	logic [3:0]  sel_i = 4'h0;
	logic        we_i = 1'b0;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic [7:0]  src_i = 8'h00;
	logic [31:0] dat_o, q;
	logic        ack_o, fiq_o, irq_o, int_o, secure;
	logic [7:0]  irq_cnt;
	int          failures = 0;
	int          total_checks = 0;
	initial forever #12.5 clk_i = ~clk_i;
	igr_router dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
		.ack_o(ack_o), .src_i(src_i), .fiq_o(fiq_o), .irq_o(irq_o), .int_o(int_o));
	igr_core_model core (.clk_i(clk_i), .rst_i(rst_i), .fiq_i(fiq_o), .irq_i(irq_o),
		.secure_o(secure), .irq_cnt_o(irq_cnt));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// one classic cycle; called right after a rising edge
	task automatic wb(input logic [13:0] a, input logic w, input logic [31:0] d);
		int n;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			failures++;
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		wb(a, 1'b1, d);
	endtask : wr
	task automatic rdc(input logic [13:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask : rdc
	task automatic outs(input logic f, input logic i);
		chk("fiq_o", {31'h0, fiq_o}, {31'h0, f});
		chk("irq_o", {31'h0, irq_o}, {31'h0, i});
	endtask : outs
	initial begin
		repeat (4000) @(posedge clk_i);
		failures++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		outs(1'b0, 1'b0);
		rdc(`IGR_GROUP_BITS, 32'h0);
		rdc(`IGR_BP_PRIMARY, 32'h2);
		rdc(`IGR_HIGH_PEND, 32'h3ff);
		wr(`IGR_PRIO_MASK, 32'hf0);
		wr(`IGR_PRIO_LO, 32'h2010);
		wr(`IGR_GROUP_BITS, 32'h02);
		rdc(`IGR_GROUP_BITS, 32'h02);
		wr(`IGR_BP_ALIASED, 32'h7);
		wr(`IGR_DIST_CTRL, 32'h3);
		wr(`IGR_CPU_CTRL, 32'h0b);
		src_i <= 8'h01;
		repeat (8) @(posedge clk_i);
		outs(1'b1, 1'b0);
		chk("secure", {31'h0, secure}, 32'h1);
		wr(`IGR_CPU_CTRL, 32'h0a);
		outs(1'b0, 1'b0);
		wr(`IGR_CPU_CTRL, 32'h0b);
		wr(`IGR_DIST_CTRL, 32'h2);
		outs(1'b0, 1'b0);
		wr(`IGR_DIST_CTRL, 32'h3);
		rdc(`IGR_ACK_ALIASED, 32'h3ff);
		rdc(`IGR_ACK_PRIMARY, 32'h0);
		rdc(`IGR_RUN_PRIO, 32'h10);
		// group 1 candidate above running priority, blocked by aliased point 7
		wr(`IGR_PRIO_LO, 32'h0810);
		wr(`IGR_SET_PEND, 32'h02);
		outs(1'b0, 1'b0);
		wr(`IGR_CPU_CTRL, 32'h1b);
		outs(1'b0, 1'b1);
		wr(`IGR_EOI_ALIASED, 32'h0);
		rdc(`IGR_RUN_PRIO, 32'h10);
		wr(`IGR_EOI_PRIMARY, 32'h0);
		rdc(`IGR_RUN_PRIO, 32'hff);
		rdc(`IGR_ACK_ALIASED, 32'h1);
		wr(`IGR_EOI_ALIASED, 32'h1);
		rdc(`IGR_RUN_PRIO, 32'hff);
		wr(`IGR_RUN_PRIO, 32'h0);
		rdc(`IGR_RUN_PRIO, 32'hff);
		rdc(`IGR_EOI_PRIMARY, 32'h0);
		rdc(14'h3000, 32'h0);
		rdc(`IGR_EVT_STATUS, 32'h7);
		wr(`IGR_EVT_ENABLE, 32'h2);
		chk("int_o", {31'h0, int_o}, 32'h1);
		wr(`IGR_EVT_CLEAR, 32'h2);
		chk("int_o", {31'h0, int_o}, 32'h0);
		rdc(`IGR_EVT_STATUS, 32'h5);
		wr(`IGR_EVT_ENABLE, 32'h0);
		wr(`IGR_DIST_CTRL, 32'h0);
		wr(`IGR_CPU_CTRL, 32'h0);
		outs(1'b0, 1'b0);
		// one normal request edge, raised while the core was not secure
		chk("irq_cnt", {24'h0, irq_cnt}, 32'h1);
		complete_run;
	end
endmodule : test_interrupt_group_signal_routing
